// File: hw/iosr_top.sv
// i/o space decoder with bit access, flag register and timer 2 group
//
// Functional notes
// - set-bit and clear-bit act on i/o addresses 0x00 to 0x1f only, elsewhere they do nothing.
// - skip-if-set and skip-if-clear test one chosen bit of a register in the low range.
// - flags clear when software writes one to their bit and stay when it writes zero.
// - a set-bit or clear-bit touches only the addressed bit, never the other flags.
// - dedicated in and out accesses reach the 64 i/o locations 0x00 to 0x3f.
// - loads and stores see each i/o register at its i/o address plus 0x20.
// - the extended registers at 0x60 to 0xff are reached by loads and stores only.
`timescale 1ns/1ps
`include "iosr_map.svh"

module iosr_top #(
  parameter int unsigned FLAG_W = 3
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  input  wire iosr_pkg::iosr_req_t   req_i,
  input  wire logic [FLAG_W-1:0]     flag_set_i,
  output logic                       ready_o,
  output iosr_pkg::iosr_rsp_t        rsp_o,
  output logic [FLAG_W-1:0]          flags_o,
  output iosr_pkg::iosr_t2_cfg_t     t2_cfg_o,
  output logic [1:0]                 force_o,
  output logic                       count_wr_o
);

  if (FLAG_W == 0 || FLAG_W > 8) begin : g_chk
    $error("iosr_top: FLAG_W must be 1 to 8");
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // returns {hit, index} into the 64 dedicated i/o locations
  function automatic logic [`IOSR_IO_AW:0] io_map(input iosr_pkg::iosr_kind_t kind,
                                                  input logic [7:0] addr);
    logic [7:0] off;
    off = addr - `IOSR_IO_TO_DATA;
    io_map = '0;
    unique case (kind)
      iosr_pkg::IOSR_LOAD, iosr_pkg::IOSR_STORE: begin
        if (addr >= `IOSR_IO_TO_DATA && addr < `IOSR_EXT_FIRST) begin
          io_map = {1'b1, off[`IOSR_IO_AW-1:0]};
        end
      end
      iosr_pkg::IOSR_IO_IN, iosr_pkg::IOSR_IO_OUT: begin
        io_map = {1'b1, addr[`IOSR_IO_AW-1:0]};
      end
      default: begin
        if (addr <= `IOSR_BIT_LAST) begin
          io_map = {1'b1, addr[`IOSR_IO_AW-1:0]};
        end
      end
    endcase
  endfunction

  function automatic logic is_write(input iosr_pkg::iosr_kind_t kind);
    is_write = (kind == iosr_pkg::IOSR_IO_OUT) || (kind == iosr_pkg::IOSR_STORE);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic {IOSR_IDLE, IOSR_BUSY} iosr_state_t;

  iosr_state_t             state_reg,   state_next;
  iosr_pkg::iosr_req_t     req_reg,     req_next;
  iosr_pkg::iosr_rsp_t     rsp_reg,     rsp_next;
  iosr_pkg::iosr_t2_cfg_t  t2_reg,      t2_next;
  logic [FLAG_W-1:0]       flags_reg,   flags_next;
  logic [FLAG_W-1:0]       flag_clr;
  logic                    ready_reg,   ready_next;
  logic [1:0]              force_reg,   force_next;
  logic                    count_wr_reg, count_wr_next;

  logic [`IOSR_IO_AW:0]    acc_map;
  logic [`IOSR_IO_AW:0]    cur_map;
  logic [7:0]              mem_rdata;
  logic                    mem_we;
  logic [7:0]              mem_wdata;
  logic [7:0]              cur_val;
  logic [7:0]              bit_mask;
  logic                    on_flag;
  logic                    accept;

  assign accept  = req_i.valid && ready_reg && (state_reg == IOSR_IDLE);
  assign acc_map = io_map(req_i.kind, req_i.addr);
  assign cur_map = io_map(req_reg.kind, req_reg.addr);
  assign on_flag = cur_map[`IOSR_IO_AW] &&
                   (cur_map[`IOSR_IO_AW-1:0] == `IOSR_FLAG_IO);
  assign bit_mask = `IOSR_ONE_BYTE << req_reg.bit_sel;

  iosr_mem #(
    .WIDTH (8),
    .DEPTH (64),
    .AW    (`IOSR_IO_AW)
  ) u_mem (
    .clock_i (clock_i),
    .raddr_i (acc_map[`IOSR_IO_AW-1:0]),
    .we_i    (mem_we),
    .waddr_i (cur_map[`IOSR_IO_AW-1:0]),
    .wdata_i (mem_wdata),
    .rdata_o (mem_rdata)
  );

  // ----------------------------------------------------------------
  // hardware flag setting
  // ----------------------------------------------------------------
  // an event in the clearing cycle survives: set wins over clear
  for (genvar g = 0; g < FLAG_W; g++) begin : g_flag
    assign flags_next[g] = flag_set_i[g] | (flags_reg[g] & ~flag_clr[g]);
  end

  // ----------------------------------------------------------------
  // access sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_next    = state_reg;
    req_next      = req_reg;
    rsp_next      = rsp_reg;
    rsp_next.ack  = 1'b0;
    t2_next       = t2_reg;
    ready_next    = ready_reg;
    force_next    = 2'b00;
    count_wr_next = 1'b0;
    flag_clr      = '0;
    mem_we        = 1'b0;
    mem_wdata     = mem_rdata;
    cur_val       = `IOSR_ZERO_BYTE;

    // reserved bits and unmapped places read zero
    if (on_flag) begin
      cur_val[FLAG_W-1:0] = flags_reg;
    end else if (cur_map[`IOSR_IO_AW]) begin
      cur_val = mem_rdata;
    end else if (req_reg.kind == iosr_pkg::IOSR_LOAD) begin
      unique case (req_reg.addr)
        `IOSR_T2_CTRL_A: cur_val = t2_reg.ctrl_a;
        `IOSR_T2_CTRL_B: cur_val = t2_reg.ctrl_b;
        `IOSR_T2_COUNT:  cur_val = t2_reg.count;
        `IOSR_T2_CMP_A:  cur_val = t2_reg.cmp_a;
        `IOSR_T2_CMP_B:  cur_val = t2_reg.cmp_b;
        default:         cur_val = `IOSR_ZERO_BYTE;
      endcase
    end

    unique case (state_reg)
      IOSR_IDLE: begin
        if (accept) begin
          req_next   = req_i;
          ready_next = 1'b0;
          state_next = IOSR_BUSY;
        end
      end
      IOSR_BUSY: begin
        rsp_next.ack   = 1'b1;
        rsp_next.rdata = `IOSR_ZERO_BYTE;
        rsp_next.skip  = 1'b0;
        ready_next     = 1'b1;
        state_next     = IOSR_IDLE;
        unique case (req_reg.kind)
          iosr_pkg::IOSR_IO_IN, iosr_pkg::IOSR_LOAD: begin
            rsp_next.rdata = cur_val;
          end
          iosr_pkg::IOSR_IO_OUT, iosr_pkg::IOSR_STORE: begin
            if (on_flag) begin
              flag_clr = req_reg.wdata[FLAG_W-1:0];
            end else if (cur_map[`IOSR_IO_AW]) begin
              mem_we    = 1'b1;
              mem_wdata = req_reg.wdata;
            end else if (req_reg.kind == iosr_pkg::IOSR_STORE) begin
              // reserved extended addresses fall through untouched
              unique case (req_reg.addr)
                `IOSR_T2_CTRL_A: t2_next.ctrl_a = req_reg.wdata & `IOSR_CTRL_A_MASK;
                `IOSR_T2_CTRL_B: begin
                  t2_next.ctrl_b = req_reg.wdata & `IOSR_CTRL_B_MASK;
                  force_next = req_reg.wdata[`IOSR_FORCE_MSB:`IOSR_FORCE_LSB];
                end
                `IOSR_T2_COUNT: begin
                  t2_next.count = req_reg.wdata;
                  count_wr_next = 1'b1;
                end
                `IOSR_T2_CMP_A: t2_next.cmp_a = req_reg.wdata;
                `IOSR_T2_CMP_B: t2_next.cmp_b = req_reg.wdata;
                default: begin
                end
              endcase
            end
          end
          iosr_pkg::IOSR_SET_BIT, iosr_pkg::IOSR_CLEAR_BIT: begin
            // only the addressed bit is written, so neighbour flags keep their state
            if (on_flag) begin
              if (req_reg.kind == iosr_pkg::IOSR_SET_BIT) begin
                flag_clr = bit_mask[FLAG_W-1:0];
              end
            end else if (cur_map[`IOSR_IO_AW]) begin
              mem_we    = 1'b1;
              mem_wdata = (req_reg.kind == iosr_pkg::IOSR_SET_BIT) ?
                          (mem_rdata | bit_mask) : (mem_rdata & ~bit_mask);
            end
          end
          default: begin
            if (cur_map[`IOSR_IO_AW]) begin
              rsp_next.skip = (cur_val[req_reg.bit_sel] ==
                               (req_reg.kind == iosr_pkg::IOSR_SKIP_IF_SET));
            end
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg    <= IOSR_IDLE;
      req_reg      <= '0;
      rsp_reg      <= '0;
      t2_reg       <= {5{`IOSR_RST_BYTE}};
      flags_reg    <= '0;
      ready_reg    <= 1'b1;
      force_reg    <= 2'b00;
      count_wr_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      req_reg      <= req_next;
      rsp_reg      <= rsp_next;
      t2_reg       <= t2_next;
      flags_reg    <= flags_next;
      ready_reg    <= ready_next;
      force_reg    <= force_next;
      count_wr_reg <= count_wr_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign ready_o    = ready_reg;
  assign rsp_o      = rsp_reg;
  assign flags_o    = flags_reg;
  assign t2_cfg_o   = t2_reg;
  assign force_o    = force_reg;
  assign count_wr_o = count_wr_reg;

endmodule

// File: hw/iosr_map.svh
// address map, field masks and reset values of the i/o register block
`ifndef IOSR_MAP_SVH
`define IOSR_MAP_SVH

// ----------------------------------------------------------------
// address ranges
// ----------------------------------------------------------------
`define IOSR_BIT_LAST    8'h1f
`define IOSR_IO_LAST     8'h3f
`define IOSR_IO_TO_DATA  8'h20
`define IOSR_EXT_FIRST   8'h60
`define IOSR_IO_AW       6

// ----------------------------------------------------------------
// register locations
// ----------------------------------------------------------------
`define IOSR_FLAG_IO     6'h17
`define IOSR_T2_CTRL_A   8'hb0
`define IOSR_T2_CTRL_B   8'hb1
`define IOSR_T2_COUNT    8'hb2
`define IOSR_T2_CMP_A    8'hb3
`define IOSR_T2_CMP_B    8'hb4

// ----------------------------------------------------------------
// field masks and reset values
// ----------------------------------------------------------------
`define IOSR_CTRL_A_MASK 8'hf3
`define IOSR_CTRL_B_MASK 8'h0f
`define IOSR_FORCE_MSB   7
`define IOSR_FORCE_LSB   6
`define IOSR_RST_BYTE    8'h00
`define IOSR_ZERO_BYTE   8'h00
`define IOSR_ONE_BYTE    8'h01

`endif

// File: hw/iosr_pkg.sv
// types shared by the i/o register block
package iosr_pkg;

  // ----------------------------------------------------------------
  // access kinds issued by the core
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IOSR_IO_IN,
    IOSR_IO_OUT,
    IOSR_LOAD,
    IOSR_STORE,
    IOSR_SET_BIT,
    IOSR_CLEAR_BIT,
    IOSR_SKIP_IF_SET,
    IOSR_SKIP_IF_CLEAR
  } iosr_kind_t;

  typedef struct packed {
    logic       valid;
    iosr_kind_t kind;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [2:0] bit_sel;
  } iosr_req_t;

  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
    logic       skip;
  } iosr_rsp_t;

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] count;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
  } iosr_t2_cfg_t;

endpackage

// File: hw/iosr_mem.sv
// byte store behind the 64 dedicated i/o locations
`timescale 1ns/1ps
`include "iosr_map.svh"

module iosr_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 64,
  parameter int unsigned AW    = 6
) (
  input  wire logic             clock_i,
  input  wire logic [AW-1:0]    raddr_i,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  output logic      [WIDTH-1:0] rdata_o
);

  if (DEPTH > (1 << AW) || WIDTH == 0) begin : g_chk
    $error("iosr_mem: depth does not fit address width");
  end

  logic [WIDTH-1:0] store_reg [DEPTH];

  // no reset on the array: contents are software defined
  always_ff @(posedge clock_i) begin
    if (we_i) begin
      store_reg[waddr_i] <= wdata_i;
    end
    rdata_o <= store_reg[raddr_i];
  end

endmodule

// File: bench/iosr_monitor.sv
// concurrent checks on the i/o register block ports
`timescale 1ns/1ps
module iosr_monitor #(
  parameter int unsigned FLAG_W = 3
) (
  input wire logic                   clock_i,
  input wire logic                   rst_n_i,
  input wire iosr_pkg::iosr_req_t    req_i,
  input wire logic [FLAG_W-1:0]      flag_set_i,
  input wire logic                   ready_o,
  input wire iosr_pkg::iosr_rsp_t    rsp_o,
  input wire logic [FLAG_W-1:0]      flags_o,
  input wire iosr_pkg::iosr_t2_cfg_t t2_cfg_o,
  input wire logic [1:0]             force_o,
  input wire logic                   count_wr_o
);
  logic take;
  logic wr;
  assign take = req_i.valid && ready_o;
  assign wr = req_i.kind inside {iosr_pkg::IOSR_IO_OUT, iosr_pkg::IOSR_STORE,
                                 iosr_pkg::IOSR_SET_BIT};
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------
  // access handshake
  // ----------------------------------------------------------------
  sequence s_take; take; endsequence
  sequence s_gap; !ready_o ##1 ready_o; endsequence
  a_ack_after_take: assert property (s_take |-> ##2 rsp_o.ack)
    else $error("ack missing two edges after take");
  a_ready_gap: assert property (s_take |=> s_gap)
    else $error("ready gap wrong after take");
  a_ack_has_take: assert property (rsp_o.ack |-> $past(take, 2) && !$past(rsp_o.ack))
    else $error("ack without take");
  // ----------------------------------------------------------------
  // bit range, flags, extended space
  // ----------------------------------------------------------------
  a_skip_low_only: assert property (s_take and req_i.kind[2:1] == 2'b11
    && req_i.addr > 8'h1f |-> ##2 !rsp_o.skip)
    else $error("skip outside bit range");
  a_flag_set_sticky: assert property (flag_set_i[0] |=> flags_o[0])
    else $error("flag event lost");
  a_flag_clear_cause: assert property ($fell(flags_o[0]) |-> $past(take && wr, 2))
    else $error("flag cleared without write");
  a_io_no_timer: assert property (s_take and req_i.kind == iosr_pkg::IOSR_IO_OUT
    |-> ##2 $stable(t2_cfg_o))
    else $error("io out reached timer group");
  a_count_strobe: assert property (count_wr_o |-> rsp_o.ack && $past(take && req_i.kind
    == iosr_pkg::IOSR_STORE && req_i.addr == 8'hb2, 2))
    else $error("count strobe without store");
  a_force_strobe: assert property (force_o != 2'h0 |-> rsp_o.ack)
    else $error("force strobe outside ack");
  a_reserved_bits: assert property (t2_cfg_o.ctrl_a[3:2] == 2'h0
    && t2_cfg_o.ctrl_b[7:4] == 4'h0)
    else $error("reserved control bit set");
endmodule
bind iosr_top iosr_monitor #(.FLAG_W(FLAG_W)) u_mon (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .req_i(req_i), .flag_set_i(flag_set_i), .ready_o(ready_o), .rsp_o(rsp_o),
  .flags_o(flags_o), .t2_cfg_o(t2_cfg_o), .force_o(force_o), .count_wr_o(count_wr_o));

// File: bench/iosr_core_model.sv
// processor core model issuing register accesses
`timescale 1ns/1ps
module iosr_core_model (
  input  wire logic          clock_i,
  input  wire logic          ready_i,
  input  wire iosr_pkg::iosr_rsp_t rsp_i,
  output iosr_pkg::iosr_req_t      req_o
);
  initial req_o = '0;
  // callers write only implemented places
  // reserved bits are set only where their zero readback is checked
  task automatic acc(input iosr_pkg::iosr_kind_t k, input logic [7:0] a, input logic [7:0] w,
                     input logic [2:0] b, output logic [7:0] rd, output logic sk,
                     output logic ak);
    int n;
    n = 0;
    @(posedge clock_i);
    #1;
    req_o = '{valid: 1'b1, kind: k, addr: a, wdata: w, bit_sel: b};
    // ready is registered, so its value just after an edge holds at the next one
    while (ready_i !== 1'b1 && n < 8) begin
      n++;
      @(posedge clock_i);
      #1;
    end
    @(posedge clock_i);
    #1;
    // released fields flip so stale values never look valid
    req_o.valid = 1'b0;
    req_o.addr  = ~a;
    req_o.wdata = ~w;
    @(posedge clock_i);
    #1;
    rd = rsp_i.rdata;
    sk = rsp_i.skip;
    ak = rsp_i.ack;
  endtask
endmodule

// File: bench/iosr_top_bench.sv
// directed bench for the i/o register block
`timescale 1ns/1ps
module iosr_top_bench;
  localparam iosr_pkg::iosr_kind_t K_IN = iosr_pkg::IOSR_IO_IN;
  localparam iosr_pkg::iosr_kind_t K_OUT = iosr_pkg::IOSR_IO_OUT;
  localparam iosr_pkg::iosr_kind_t K_LD = iosr_pkg::IOSR_LOAD;
  localparam iosr_pkg::iosr_kind_t K_ST = iosr_pkg::IOSR_STORE;
  localparam iosr_pkg::iosr_kind_t K_SB = iosr_pkg::IOSR_SET_BIT;
  localparam iosr_pkg::iosr_kind_t K_CB = iosr_pkg::IOSR_CLEAR_BIT;
  localparam iosr_pkg::iosr_kind_t K_SS = iosr_pkg::IOSR_SKIP_IF_SET;
  localparam iosr_pkg::iosr_kind_t K_SC = iosr_pkg::IOSR_SKIP_IF_CLEAR;
  logic                   clock_i;
  logic                   rst_n_i;
  iosr_pkg::iosr_req_t    req;
  logic [2:0]             flag_set;
  logic                   ready;
  iosr_pkg::iosr_rsp_t    rsp;
  logic [2:0]             flags;
  iosr_pkg::iosr_t2_cfg_t cfg;
  logic [1:0]             frc;
  logic                   cnt_wr;
  logic [7:0]             rd;
  logic                   sk;
  logic                   ak;
  int                     bad_count = 0;
  int                     cmp_count = 0;
  int                     cycles = 0;
  logic [7:0]             tmask [5] = '{8'hf3, 8'h0f, 8'hff, 8'hff, 8'hff};

  iosr_top u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req), .flag_set_i(flag_set),
    .ready_o(ready), .rsp_o(rsp), .flags_o(flags), .t2_cfg_o(cfg), .force_o(frc),
    .count_wr_o(cnt_wr));
  iosr_core_model u_core (.clock_i(clock_i), .ready_i(ready), .rsp_i(rsp), .req_o(req));

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic op(input iosr_pkg::iosr_kind_t k, input logic [7:0] a, input logic [7:0] w,
                    input logic [2:0] b);
    u_core.acc(k, a, w, b, rd, sk, ak);
    chk1(ak, 1'b1);
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ceiling well above the under two hundred cycles the tests need
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    flag_set = 3'h0;
    repeat (20) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    chk8(cfg.ctrl_b, 8'h00);
    op(K_OUT, 8'h05, 8'ha5, 3'h0);
    op(K_LD, 8'h25, 8'h00, 3'h0);
    chk8(rd, 8'ha5);
    op(K_IN, 8'h45, 8'h00, 3'h0);
    chk8(rd, 8'ha5);
    op(K_ST, 8'h5e, 8'h3c, 3'h0);
    op(K_IN, 8'h3e, 8'h00, 3'h0);
    chk8(rd, 8'h3c);
    op(K_LD, 8'h10, 8'h00, 3'h0);
    chk8(rd, 8'h00);
    $display("test map done");
    op(K_SB, 8'h05, 8'h00, 3'h1);
    op(K_CB, 8'h05, 8'h00, 3'h7);
    op(K_SS, 8'h05, 8'h00, 3'h0);
    chk1(sk, 1'b1);
    op(K_SS, 8'h05, 8'h00, 3'h3);
    chk1(sk, 1'b0);
    op(K_SC, 8'h05, 8'h00, 3'h3);
    chk1(sk, 1'b1);
    op(K_IN, 8'h05, 8'h00, 3'h0);
    chk8(rd, 8'h27);
    op(K_OUT, 8'h25, 8'h00, 3'h0);
    op(K_SB, 8'h25, 8'h00, 3'h2);
    op(K_SC, 8'h25, 8'h00, 3'h2);
    chk1(sk, 1'b0);
    op(K_IN, 8'h25, 8'h00, 3'h0);
    chk8(rd, 8'h00);
    $display("test bits done");
    @(posedge clock_i);
    #1;
    flag_set = 3'h7;
    @(posedge clock_i);
    #1;
    flag_set = 3'h0;
    op(K_OUT, 8'h17, 8'h01, 3'h0);
    op(K_OUT, 8'h17, 8'h00, 3'h0);
    op(K_CB, 8'h17, 8'h00, 3'h2);
    op(K_IN, 8'h17, 8'h00, 3'h0);
    chk8(rd, 8'h06);
    op(K_SB, 8'h17, 8'h00, 3'h1);
    op(K_LD, 8'h37, 8'h00, 3'h0);
    chk8(rd, 8'h04);
    $display("test flags done");
    for (int i = 0; i < 5; i++) begin
      op(K_ST, 8'hb0 + 8'(i), 8'h3f, 3'h0);
      chk1(cnt_wr, i == 2);
      op(K_OUT, 8'hb0 + 8'(i), 8'h3c, 3'h0);
      op(K_LD, 8'hb0 + 8'(i), 8'h00, 3'h0);
      chk8(rd, 8'h3f & tmask[i]);
      op(K_IN, 8'hb0 + 8'(i), 8'h00, 3'h0);
      chk8(rd, 8'h3c);
    end
    op(K_ST, 8'hb1, 8'hc5, 3'h0);
    chk8({6'h00, frc}, 8'h03);
    chk8(cfg.ctrl_b, 8'h05);
    op(K_OUT, 8'h30, 8'h00, 3'h0);
    chk8(cfg.count, 8'h3f);
    op(K_LD, 8'ha0, 8'h00, 3'h0);
    chk8(rd, 8'h00);
    $display("test timer done");
    @(posedge clock_i);
    #1;
    rst_n_i = 1'b0;
    #1;
    chk8(cfg.count, 8'h00);
    chk8({5'h00, flags}, 8'h00);
    chk1(ready, 1'b1);
    repeat (2) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    op(K_LD, 8'hb1, 8'h00, 3'h0);
    chk8(rd, 8'h00);
    $display("test reset done");
    conclude();
  end
endmodule
